// >>> rtl/cc_unit_consts.svh
// Register offsets, field positions, reset values and timing counts of the capture/compare unit
`ifndef CC_UNIT_CONSTS_SVH
`define CC_UNIT_CONSTS_SVH

// Word offsets of the registers (byte address = 4 * index)
`define OFS_EVENT_FLAGS      8'hc8
`define OFS_SET_ENABLE       8'hee
`define OFS_IRQ_PRIORITY     8'hf8
`define OFS_EDGE_SELECT      8'heb
`define OFS_CLR_TGL_ENABLE   8'hef
`define OFS_TIMER_CONTROL    8'hea
`define OFS_CMP0_LO          8'ha9
`define OFS_CMP1_LO          8'haa
`define OFS_CMP2_LO          8'hab
`define OFS_CMP0_HI          8'hc9
`define OFS_CMP1_HI          8'hca
`define OFS_CMP2_HI          8'hcb
`define OFS_CAP0_LO          8'hac
`define OFS_CAP0_HI          8'hcc
`define OFS_PORT_LATCH       8'hc0

// Field positions
`define FLD_WIDE_OVF         7
`define FLD_MATCH0           4
`define FLD_CAPTURE0         0
`define FLD_BYTE_OVF         4
`define FLD_TOGGLE_LO        6

// Reset values
`define RST_PORT_LATCH       8'hff
`define RST_TOGGLE_STATE     2'h3

// Machine cycle: six states of two phases at the system clock
`define STATES_PER_CYCLE     6
`define PHASES_PER_CYCLE     4'hc
`define PH_S1P1              4'h0
`define PH_S4P1              4'h6
`define PH_S5P1              4'h8
`define PH_S6P1              4'ha

`endif

// >>> rtl/cc_unit_pkg.sv
// Types of the capture/compare unit
package cc_unit_pkg;

  // Bus slave phase: idle, then one answer cycle
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

endpackage

// >>> rtl/timer_capture_compare_unit.sv
// Compare and capture logic beside a free-running 16-bit timer, Wishbone register slave
// How it works
// - Each timer increment compares three compare registers
// - Compare zero match sets enabled bits 0-5
// - Compare one match clears enabled bits 0-5
// - Compare two match toggles private state bits 6-7
// - Toggle follows state flip-flop, first toggle sets
// - Toggle states read-only in set-enable bits 6-7
// - Reset clears all three compare registers
// - Match reaches pin S5P1, software write S1P1
// - Match change beats same-cycle software write
// - Simultaneous set and clear ends cleared
// - Capture select: falling bit 2n+1, rising 2n
// - Clear/toggle enable: toggles 7-6, clears 5-0
// - Set-enable bits 5-0 enable setting outputs
// - Flags: overflow 7, matches 6-4, captures 3-0
// - Byte overflow flag in timer control bit 4
// - Capture flags 0,1 set S4; 2,3 set S6
// - Scan phases of flags per source fixed
// - Match flags set S6 of following cycle
// - Overflow flags set S6 of overflow cycle
// - Priority register one bit per source, bit 7 shared by both overflows
// - Capture inputs sampled once per cycle, S1P1
`timescale 1ns/1ps
`default_nettype none
`include "cc_unit_consts.svh"

module timer_capture_compare_unit #(
  parameter int TIMER_W = 16
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  // Wishbone classic slave
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [9:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  // Timer counter side
  input  wire logic [TIMER_W-1:0] free_run_timer,
  input  wire logic               timer_inc,
  input  wire logic               wide_overflow,
  input  wire logic               byte_overflow,
  // Capture pins
  input  wire logic [3:0]         capture_in,
  // Output port and interrupt side
  output logic      [7:0]         compare_out_port,
  output logic      [8:0]         irq_request,
  output logic      [8:0]         irq_high_prio
);

  typedef struct packed {
    cc_unit_pkg::bus_state_t   bus;
    logic [31:0]               rdata;
    logic [3:0]                phase;
    logic [TIMER_W-1:0]        cmp0;
    logic [TIMER_W-1:0]        cmp1;
    logic [TIMER_W-1:0]        cmp2;
    logic [3:0][TIMER_W-1:0]   cap;
    logic [5:0]                set_en;
    logic [7:0]                clr_tgl_en;
    logic [7:0]                edge_sel;
    logic [7:0]                prio;
    logic [7:0]                flags;
    logic                      byte_ovf;
    logic [7:0]                tmr_ctl;
    logic [1:0]                tgl_state;
    logic [7:0]                latch;
    logic [7:0]                pin;
    logic [2:0]                match_pend;
    logic [2:0]                match_seen;
    logic                      hw_pend;
    logic                      sw_pend;
    logic [3:0]                cap_prev;
    logic [3:0]                cap_hit;
    logic [3:0]                cap_seen;
    logic [1:0]                ovf_hit;
    logic [8:0]                scanned;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic       bus_req;
  logic [7:0] word_idx;
  logic [7:0] wbyte;
  logic       wr_en;
  logic [2:0] match_now;
  logic [3:0] edge_hit;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic [7:0] sw_latch;
  logic [7:0] rd_byte;
  logic [8:0] all_flags;
  logic       at_s1, at_s4, at_s5, at_s6, end_cyc;

  assign bus_req  = wb_cyc_i && wb_stb_i;
  assign word_idx = wb_adr_i[9:2];
  assign wbyte    = wb_dat_i[7:0];
  // Write takes effect only on the acked edge
  assign wr_en    = bus_req && wb_we_i && wb_sel_i[0] && (st_r.bus == cc_unit_pkg::BUS_ACK);
  assign at_s1    = (st_r.phase == `PH_S1P1);
  assign at_s4    = (st_r.phase == `PH_S4P1);
  assign at_s5    = (st_r.phase == `PH_S5P1);
  assign at_s6    = (st_r.phase == `PH_S6P1);
  assign end_cyc  = (st_r.phase == `PHASES_PER_CYCLE - 4'h1);

  // Comparators act only on increment cycles
  assign match_now[0] = timer_inc && (free_run_timer == st_r.cmp0);
  assign match_now[1] = timer_inc && (free_run_timer == st_r.cmp1);
  assign match_now[2] = timer_inc && (free_run_timer == st_r.cmp2);

  // Per-channel edge detect against the last once-per-cycle sample
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_edge
      assign edge_hit[gi] =
        (st_r.edge_sel[2*gi]   && !st_r.cap_prev[gi] && capture_in[gi]) ||
        (st_r.edge_sel[2*gi+1] && st_r.cap_prev[gi] && !capture_in[gi]);
    end
  endgenerate

  // Set/clear masks from matches; clear applied after set so it wins
  assign set_mask = {st_r.match_pend[2] & st_r.clr_tgl_en[7] & st_r.tgl_state[1],
                     st_r.match_pend[2] & st_r.clr_tgl_en[6] & st_r.tgl_state[0],
                     {6{st_r.match_pend[0]}} & st_r.set_en};
  assign clr_mask = {st_r.match_pend[2] & st_r.clr_tgl_en[7] & ~st_r.tgl_state[1],
                     st_r.match_pend[2] & st_r.clr_tgl_en[6] & ~st_r.tgl_state[0],
                     {6{st_r.match_pend[1]}} & st_r.clr_tgl_en[5:0]};

  // Software view of the latch before the hardware override
  assign sw_latch = (wr_en && word_idx == `OFS_PORT_LATCH) ? wbyte : st_r.latch;

  // Read multiplexer; unmapped words read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (word_idx)
      `OFS_EVENT_FLAGS:    rd_byte = st_r.flags;
      `OFS_SET_ENABLE:     rd_byte = {st_r.tgl_state, st_r.set_en};
      `OFS_IRQ_PRIORITY:   rd_byte = st_r.prio;
      `OFS_EDGE_SELECT:    rd_byte = st_r.edge_sel;
      `OFS_CLR_TGL_ENABLE: rd_byte = st_r.clr_tgl_en;
      `OFS_TIMER_CONTROL:  rd_byte = st_r.tmr_ctl | ({7'h00, st_r.byte_ovf} << `FLD_BYTE_OVF);
      `OFS_CMP0_LO:        rd_byte = st_r.cmp0[7:0];
      `OFS_CMP1_LO:        rd_byte = st_r.cmp1[7:0];
      `OFS_CMP2_LO:        rd_byte = st_r.cmp2[7:0];
      `OFS_CMP0_HI:        rd_byte = st_r.cmp0[15:8];
      `OFS_CMP1_HI:        rd_byte = st_r.cmp1[15:8];
      `OFS_CMP2_HI:        rd_byte = st_r.cmp2[15:8];
      `OFS_PORT_LATCH:     rd_byte = st_r.latch;
      default: begin
        if (word_idx >= `OFS_CAP0_LO && word_idx < `OFS_CAP0_LO + 8'h4) begin
          rd_byte = st_r.cap[word_idx[1:0]][7:0];
        end else if (word_idx >= `OFS_CAP0_HI && word_idx < `OFS_CAP0_HI + 8'h4) begin
          rd_byte = st_r.cap[word_idx[1:0]][15:8];
        end
      end
    endcase
  end

  assign all_flags = {st_r.byte_ovf, st_r.flags};

  // Next-state logic of the whole unit
  always_comb begin
    st_nxt = st_r;

    // Bus: answer one cycle after the request, drop the next cycle
    st_nxt.bus = (bus_req && st_r.bus == cc_unit_pkg::BUS_IDLE) ?
                 cc_unit_pkg::BUS_ACK : cc_unit_pkg::BUS_IDLE;
    if (bus_req && st_r.bus == cc_unit_pkg::BUS_IDLE && !wb_we_i) begin
      st_nxt.rdata = {24'h000000, rd_byte};
    end

    // Six states, two phases each
    st_nxt.phase = end_cyc ? 4'h0 : st_r.phase + 4'h1;

    // Register writes; software clears flags
    if (wr_en) begin
      unique case (word_idx)
        `OFS_SET_ENABLE:     st_nxt.set_en = wbyte[5:0];
        `OFS_IRQ_PRIORITY:   st_nxt.prio = wbyte;
        `OFS_EDGE_SELECT:    st_nxt.edge_sel = wbyte;
        `OFS_CLR_TGL_ENABLE: st_nxt.clr_tgl_en = wbyte;
        `OFS_EVENT_FLAGS:    st_nxt.flags = wbyte;
        `OFS_TIMER_CONTROL: begin
          st_nxt.tmr_ctl = wbyte & ~(8'h01 << `FLD_BYTE_OVF);
          st_nxt.byte_ovf = wbyte[`FLD_BYTE_OVF];
        end
        `OFS_CMP0_LO:        st_nxt.cmp0[7:0] = wbyte;
        `OFS_CMP1_LO:        st_nxt.cmp1[7:0] = wbyte;
        `OFS_CMP2_LO:        st_nxt.cmp2[7:0] = wbyte;
        `OFS_CMP0_HI:        st_nxt.cmp0[15:8] = wbyte;
        `OFS_CMP1_HI:        st_nxt.cmp1[15:8] = wbyte;
        `OFS_CMP2_HI:        st_nxt.cmp2[15:8] = wbyte;
        default: ;
      endcase
    end

    // Matches held until the end of the cycle they occur in
    st_nxt.match_seen = st_r.match_seen | match_now;
    if (end_cyc) begin
      st_nxt.match_pend = st_r.match_seen | match_now;
      st_nxt.match_seen = 3'h0;
    end

    // Port latch: software first, compare override after (set then clear)
    st_nxt.latch = sw_latch;
    if (at_s4) begin
      st_nxt.latch = (sw_latch | set_mask) & ~clr_mask;
      st_nxt.hw_pend = |(set_mask | clr_mask);
      if (st_r.match_pend[2]) begin
        st_nxt.tgl_state = st_r.tgl_state ^ st_r.clr_tgl_en[7:6];
      end
    end
    if (wr_en && word_idx == `OFS_PORT_LATCH) begin
      st_nxt.sw_pend = 1'b1;
    end

    // Pin update: compare change at S5P1 of the next cycle, software at S1P1
    if (at_s5 && st_r.hw_pend) begin
      st_nxt.pin = st_r.latch;
      st_nxt.hw_pend = 1'b0;
    end
    if (at_s1 && st_r.sw_pend) begin
      st_nxt.pin = st_r.latch;
      st_nxt.sw_pend = 1'b0;
    end

    // Match flags rise at S6 of the cycle after the match; set beats clear
    if (at_s6) begin
      st_nxt.flags[`FLD_MATCH0 +: 3] = st_nxt.flags[`FLD_MATCH0 +: 3] | st_r.match_pend;
      st_nxt.match_pend = 3'h0;
    end

    // Captures: sample pins at S1P1, load timer at end of cycle
    if (at_s1) begin
      st_nxt.cap_prev = capture_in;
      st_nxt.cap_seen = st_r.cap_seen | edge_hit;
    end
    for (int i = 0; i < 4; i++) begin
      if (end_cyc && st_r.cap_seen[i]) begin
        st_nxt.cap[i] = free_run_timer;
        st_nxt.cap_hit[i] = 1'b1;
        st_nxt.cap_seen[i] = 1'b0;
      end
    end
    if (at_s4) begin
      st_nxt.flags[1:0] = st_nxt.flags[1:0] | st_r.cap_hit[1:0];
      st_nxt.cap_hit[1:0] = 2'h0;
    end
    if (at_s6) begin
      st_nxt.flags[3:2] = st_nxt.flags[3:2] | st_r.cap_hit[3:2];
      st_nxt.cap_hit[3:2] = 2'h0;
    end

    // Overflows caught during the cycle, flagged at its S6
    st_nxt.ovf_hit = st_r.ovf_hit | {wide_overflow, byte_overflow};
    if (at_s6) begin
      st_nxt.flags[`FLD_WIDE_OVF] = st_nxt.flags[`FLD_WIDE_OVF] | st_nxt.ovf_hit[1];
      st_nxt.byte_ovf = st_nxt.byte_ovf | st_nxt.ovf_hit[0];
      st_nxt.ovf_hit = 2'h0;
    end

    // Interrupt scan: each flag sampled at its own state
    if (st_r.phase == 4'h2) begin
      st_nxt.scanned[0] = all_flags[0];
      st_nxt.scanned[4] = all_flags[4];
    end
    if (st_r.phase == 4'h4) begin
      st_nxt.scanned[1] = all_flags[1];
      st_nxt.scanned[5] = all_flags[5];
    end
    if (st_r.phase == 4'h6) begin
      st_nxt.scanned[2] = all_flags[2];
      st_nxt.scanned[6] = all_flags[6];
    end
    if (at_s5) begin
      st_nxt.scanned[3] = all_flags[3];
    end
    if (end_cyc) begin
      st_nxt.scanned[8:7] = all_flags[8:7];
    end
  end

  // State register; reset clears compares and sets toggle states
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r           <= '0;
      st_r.latch     <= `RST_PORT_LATCH;
      st_r.pin       <= `RST_PORT_LATCH;
      st_r.tgl_state <= `RST_TOGGLE_STATE;
      st_r.cap_prev  <= 4'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o         = (st_r.bus == cc_unit_pkg::BUS_ACK) && bus_req;
  assign wb_dat_o         = st_r.rdata;
  assign compare_out_port = st_r.pin;
  assign irq_request      = st_r.scanned;
  assign irq_high_prio    = {st_r.prio[7], st_r.prio};

endmodule // timer_capture_compare_unit

`default_nettype wire

// >>> tb/tcu_checker.sv
// Bus, port and priority assertions for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tcu_checker (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic [7:0]  compare_out_port,
  input wire logic [8:0]  irq_request,
  input wire logic [8:0]  irq_high_prio
);
  logic [3:0] phase_r;
  // Own phase count, restarted by reset just as the unit's
  always_ff @(posedge clk_sys) begin
    phase_r <= (!nrst || phase_r == 4'hb) ? 4'h0 : phase_r + 4'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
  dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
  dat_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
  prio_copy_a: assert property (
    irq_high_prio[8] == irq_high_prio[7]) else $error("byte overflow priority differs");
  // Pins move only at S1P1 or S5P1, one clock of slack for the register stage
  port_phase_a: assert property (
    $changed(compare_out_port) |-> phase_r inside {4'h0, 4'h1, 4'h8, 4'h9})
    else $error("port changed off phase");
  reset_out_a: assert property ($rose(nrst) |->
    compare_out_port == 8'hff && irq_request == 9'h0 && !wb_ack_o) else $error("bad reset state");
endmodule // tcu_checker

bind timer_capture_compare_unit tcu_checker tcu_checker_i (
  .clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .compare_out_port(compare_out_port),
  .irq_request(irq_request), .irq_high_prio(irq_high_prio));
`default_nettype wire

// >>> tb/timer_model.sv
// Free-running timer feeding count, increment strobe and overflow pulses
`timescale 1ns/1ps
`default_nettype none
module timer_model (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        run,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  output logic      [15:0] count,
  output logic             inc,
  output logic             wide_ovf,
  output logic             byte_ovf
);
  logic [3:0] div_r;
  // One increment per twelve clocks; load restarts the divider so runs are exact
  always_ff @(posedge clk_sys) begin
    inc <= 1'b0;
    wide_ovf <= 1'b0;
    byte_ovf <= 1'b0;
    if (!nrst) begin
      count <= 16'h0;
      div_r <= 4'h0;
    end else if (load) begin
      count <= load_val; // Jump without strobe
      div_r <= 4'h0;
    end else if (run) begin
      div_r <= (div_r == 4'hb) ? 4'h0 : div_r + 4'h1;
      if (div_r == 4'hb) begin
        count <= count + 16'h1;
        inc <= 1'b1;
        wide_ovf <= (count == 16'hffff);
        byte_ovf <= (count[7:0] == 8'hff);
      end
    end
  end
endmodule // timer_model
`default_nettype wire

// >>> tb/tb_timer_capture_compare_unit.sv
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
`include "cc_unit_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_timer_capture_compare_unit;
  logic        clk_sys = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, run = 1'b0, ld = 1'b0;
  logic [9:0]  adr = 10'h0;
  logic [7:0]  wd = 8'h0, q, port;
  logic [15:0] ldv = 16'h0, tmr;
  logic [3:0]  cap = 4'h0;
  logic        inc, wov, bov, ack;
  logic [31:0] rdat;
  logic [8:0]  irq, prio;
  int          num_errors = 0, comparisons = 0;
  always #2.5 clk_sys = ~clk_sys;
  timer_model timer_model_i (.clk_sys(clk_sys), .nrst(nrst), .run(run), .load(ld),
    .load_val(ldv), .count(tmr), .inc(inc), .wide_ovf(wov), .byte_ovf(bov));
  timer_capture_compare_unit timer_capture_compare_unit_i (.clk_sys(clk_sys), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i({24'h0, wd}),
    .wb_sel_i(4'h1), .wb_dat_o(rdat), .wb_ack_o(ack), .free_run_timer(tmr), .timer_inc(inc),
    .wide_overflow(wov), .byte_overflow(bov), .capture_in(cap), .compare_out_port(port),
    .irq_request(irq), .irq_high_prio(prio));
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Classic single cycle; request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wd <= d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 40);
    q = rdat[7:0];
    cyc <= 1'b0;
    if (n >= 40) begin num_errors++; print_verdict(); end
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h0);
    `CHK(nm, e, q)
  endtask
  // Load the timer, then n increments, then let flags and pins settle
  task automatic tick(input logic [15:0] v, input int n);
    @(posedge clk_sys);
    ld <= 1'b1;
    ldv <= v;
    @(posedge clk_sys);
    ld <= 1'b0;
    if (n > 0) begin
      run <= 1'b1;
      repeat (12 * n) @(posedge clk_sys);
      run <= 1'b0;
    end
    repeat (48) @(posedge clk_sys);
  endtask
  task automatic pins(input logic [3:0] v);
    cap <= v;
    repeat (48) @(posedge clk_sys);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    nrst <= 1'b1;
    rd("toggle state", `OFS_SET_ENABLE, 8'hc0);
    rd("unmapped", 8'h00, 8'h00);
    `CHK("port", 8'hff, port)
    $display("test reset done");
    bus(1'b1, `OFS_SET_ENABLE, 8'h3f);
    bus(1'b1, `OFS_CLR_TGL_ENABLE, 8'hbc);
    bus(1'b1, `OFS_PORT_LATCH, 8'h00);
    bus(1'b1, `OFS_CMP0_LO, 8'h10);
    bus(1'b1, `OFS_CMP1_LO, 8'h12);
    bus(1'b1, `OFS_CMP2_LO, 8'h14);
    tick(16'h0010, 0);
    rd("flags no strobe", `OFS_EVENT_FLAGS, 8'h00);
    rd("set enable", `OFS_SET_ENABLE, 8'hff);
    tick(16'h000f, 1);
    `CHK("port", 8'h3f, port)
    rd("flags", `OFS_EVENT_FLAGS, 8'h10);
    tick(16'h0011, 1);
    `CHK("port", 8'h03, port)
    tick(16'h0013, 1);
    `CHK("port", 8'h83, port)
    rd("toggle state", `OFS_SET_ENABLE, 8'h7f);
    bus(1'b1, `OFS_PORT_LATCH, 8'h83);
    tick(16'h0013, 1);
    `CHK("port", 8'h03, port)
    rd("toggle state", `OFS_SET_ENABLE, 8'hff);
    bus(1'b1, `OFS_CMP1_LO, 8'h10);
    bus(1'b1, `OFS_PORT_LATCH, 8'h00);
    tick(16'h000f, 1);
    `CHK("port", 8'h03, port)
    $display("test compare done");
    bus(1'b1, `OFS_EVENT_FLAGS, 8'h00);
    bus(1'b1, `OFS_EDGE_SELECT, 8'h55);
    tick(16'h1234, 0);
    pins(4'hf);
    for (int n = 0; n < 4; n++) begin
      rd("capture lo", 8'(`OFS_CAP0_LO + n), 8'h34);
      rd("capture hi", 8'(`OFS_CAP0_HI + n), 8'h12);
    end
    rd("flags", `OFS_EVENT_FLAGS, 8'h0f);
    `CHK("irq", 9'h00f, irq)
    bus(1'b1, `OFS_EVENT_FLAGS, 8'h00);
    pins(4'h0);
    rd("falling ignored", `OFS_EVENT_FLAGS, 8'h00);
    bus(1'b1, `OFS_EDGE_SELECT, 8'haa);
    tick(16'h9abc, 0);
    pins(4'hf);
    rd("rising ignored", `OFS_EVENT_FLAGS, 8'h00);
    pins(4'h0);
    rd("capture lo", 8'haf, 8'hbc);
    rd("flags", `OFS_EVENT_FLAGS, 8'h0f);
    $display("test capture done");
    bus(1'b1, `OFS_EVENT_FLAGS, 8'h00);
    tick(16'hfffe, 2);
    rd("flags", `OFS_EVENT_FLAGS, 8'h80);
    rd("timer control", `OFS_TIMER_CONTROL, 8'h10);
    `CHK("irq overflow", 2'b11, irq[8:7])
    $display("test overflow done");
    bus(1'b1, `OFS_IRQ_PRIORITY, 8'ha5);
    rd("priority", `OFS_IRQ_PRIORITY, 8'ha5);
    `CHK("irq priority", 9'h1a5, prio)
    $display("test priority done");
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd("compare after reset", `OFS_CMP1_LO, 8'h00);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_timer_capture_compare_unit
`default_nettype wire
